//--- dfd_apb.sv
// APB slave that serves the three read-only diagnostic words.
`timescale 1ns/10ps
`default_nettype none
module dfd_apb (
    // Clock and reset.
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_i,
    // APB request.
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [dfd_pkg::ADDR_W-1:0] paddr_i,
    // Diagnostic words from the core.
    input  wire logic [31:0]                diag0_i,
    input  wire logic [31:0]                diag1_i,
    input  wire logic [31:0]                diag2_i,
    // APB answer.
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o
);

    // All slave state.
    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } dfd_apb_st_t;

    dfd_apb_st_t st_r;   // Registered state.
    dfd_apb_st_t st_nxt; // Next state.

    // Answer in the second access cycle; unmapped addresses get pslverr.
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ready = 1'b0;
        st_nxt.err   = 1'b0;
        if (psel_i && penable_i && !st_r.ready)
        begin
            st_nxt.ready = 1'b1;
            st_nxt.rdata = dfd_pkg::WORD_ZERO;
            if (paddr_i == dfd_pkg::ADDR_DIAG0)
            begin
                st_nxt.rdata = pwrite_i ? dfd_pkg::WORD_ZERO : diag0_i;
            end
            else if (paddr_i == dfd_pkg::ADDR_DIAG1)
            begin
                st_nxt.rdata = pwrite_i ? dfd_pkg::WORD_ZERO : diag1_i;
            end
            else if (paddr_i == dfd_pkg::ADDR_DIAG2)
            begin
                st_nxt.rdata = pwrite_i ? dfd_pkg::WORD_ZERO : diag2_i;
            end
            else
            begin
                st_nxt.err = 1'b1;
            end
        end
    end

    // State register; writes never reach the core at all.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt; // RQ13
        end
    end

    assign prdata_o  = st_r.rdata;
    assign pready_o  = st_r.ready;
    assign pslverr_o = st_r.err;

endmodule // dfd_apb
`default_nettype wire

//--- dfd_diag.sv
// Bus access controller transfer core with its diagnostic register view.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dfd_diag #(
    parameter logic [12:0] BUF_BYTES = dfd_pkg::BUF_BYTES_DEF
) (
    // Clock and reset.
    input  wire logic                       core_clk_i,
    input  wire logic                       reset_i,
    // APB slave port.
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [dfd_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // Transfer request from the DMA arbiter.
    input  wire logic                       xfer_start_i,
    input  wire logic [dfd_pkg::CNT_W-1:0]  xfer_count_i,
    input  wire logic                       memory_to_buffer_dir_i,
    output logic                            xfer_busy_o,
    output logic                            xfer_done_o,
    // Byte handshake with the host bus master.
    input  wire logic                       byte_req_i,
    output logic                            byte_ack_o,
    output logic      [dfd_pkg::PTR_W-1:0]  host_side_buffer_pointer_o,
    output logic      [dfd_pkg::LVL_W-1:0]  host_side_buffer_level_o,
    // Buffer occupancy, same clock.
    input  wire logic [dfd_pkg::LVL_W-1:0]  buffer_used_i,
    // Requester side, asynchronous.
    input  wire logic [dfd_pkg::GID_W-1:0]  grant_id_i,
    input  wire logic [dfd_pkg::PTR_W-1:0]  transfer_start_pointer_i,
    input  wire logic [dfd_pkg::PTR_W-1:0]  net_side_buffer_pointer_i,
    output logic      [dfd_pkg::LVL_W-1:0]  net_side_buffer_level_o
);

    // All core state.
    typedef struct packed {
        dfd_pkg::dfd_fsm_t          fsm;       // Host side state.
        logic [dfd_pkg::CNT_W-1:0]  count;     // Bytes still to move.
        logic                       dir;       // One for memory to buffer.
        logic [dfd_pkg::PTR_W-1:0]  host_ptr;  // Buffer byte being accessed.
        logic [dfd_pkg::PTR_W-1:0]  start_ptr; // Start pointer of grant.
        logic [dfd_pkg::GID_W-1:0]  gid_seen;  // Grant owning start_ptr.
        logic [dfd_pkg::LVL_W-1:0]  host_lvl;  // Level shown to host side.
        logic [dfd_pkg::PTR_W-1:0]  net_ptr;   // Requester pointer sample.
        logic [dfd_pkg::LVL_W-1:0]  net_lvl;   // Level shown to requester.
        logic                       ack;       // One byte moved.
        logic                       done;      // Transfer finished.
        logic                       busy;      // Transfer in progress.
    } dfd_core_st_t;

    dfd_core_st_t st_r;   // Registered state.
    dfd_core_st_t st_nxt; // Next state.

    // Synchronised requester side values.
    logic [dfd_pkg::GID_W+dfd_pkg::PTR_W-1:0] grant_sync; // Grant and start.
    logic [dfd_pkg::PTR_W-1:0]                nptr_sync;  // Requester pointer.

    // Levels worked out from the live occupancy.
    logic [dfd_pkg::LVL_W-1:0] lvl_host; // Host side level now.
    logic [dfd_pkg::LVL_W-1:0] lvl_net;  // Requester side level now.

    // Diagnostic words presented to the bus slave.
    logic [31:0] diag0_w; // Start pointer and countdown.
    logic [31:0] diag1_w; // State, direction, pointer and level.
    logic [31:0] diag2_w; // Requester pointer and level.

    // Free space of the buffer for a given occupancy.
    function automatic logic [dfd_pkg::LVL_W-1:0] free_of(
        input logic [dfd_pkg::LVL_W-1:0] used
    );
        free_of = BUF_BYTES - used;
    endfunction

    // Grant number and start pointer travel together through one bank.
    dfd_sync #(
        .W          (dfd_pkg::GID_W + dfd_pkg::PTR_W)
    ) u_grant_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({grant_id_i, transfer_start_pointer_i}),
        .sync_o     (grant_sync)
    );

    // The requester pointer has its own bank.
    dfd_sync #(
        .W          (dfd_pkg::PTR_W)
    ) u_nptr_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (net_side_buffer_pointer_i),
        .sync_o     (nptr_sync)
    );

    // The two sides see mirrored levels: the side that drains counts data,
    // the side that fills counts empty room.
    always_comb
    begin
        lvl_host = memory_to_buffer_dir_i ? free_of(buffer_used_i) : buffer_used_i;
        lvl_net  = memory_to_buffer_dir_i ? buffer_used_i : free_of(buffer_used_i);
        if (st_r.fsm != dfd_pkg::FSM_IDLE)
        begin
            lvl_host = st_r.dir ? free_of(buffer_used_i) : buffer_used_i; // RQ9
            lvl_net  = st_r.dir ? buffer_used_i : free_of(buffer_used_i); // RQ12
        end
    end

    // Transfer state machine, start pointer capture and sampled levels.
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.ack  = 1'b0;
        st_nxt.done = 1'b0;
        // A new grant replaces the start pointer, nothing else does.
        if (grant_sync[dfd_pkg::PTR_W +: dfd_pkg::GID_W] != st_r.gid_seen)
        begin
            st_nxt.gid_seen  = grant_sync[dfd_pkg::PTR_W +: dfd_pkg::GID_W]; // RQ2
            st_nxt.start_ptr = grant_sync[dfd_pkg::PTR_W-1:0]; // RQ2
        end
        // Requester side fields are taken only from synchronised logic.
        st_nxt.net_ptr  = nptr_sync; // RQ11
        st_nxt.net_lvl  = lvl_net; // RQ10
        st_nxt.host_lvl = lvl_host; // RQ9
        case (st_r.fsm)
            dfd_pkg::FSM_IDLE:
            begin
                // Take a new transfer; its length and direction are frozen.
                if (xfer_start_i)
                begin
                    st_nxt.count = xfer_count_i; // RQ4
                    st_nxt.dir   = memory_to_buffer_dir_i; // RQ7
                    st_nxt.fsm   = dfd_pkg::FSM_LOAD;
                end
            end
            dfd_pkg::FSM_LOAD:
            begin
                // The buffer pointer starts from the granted start pointer.
                st_nxt.host_ptr = st_r.start_ptr; // RQ8
                if (st_r.count == dfd_pkg::CNT_ZERO)
                begin
                    st_nxt.fsm = dfd_pkg::FSM_DONE; // RQ5
                end
                else
                begin
                    st_nxt.fsm = dfd_pkg::FSM_MOVE;
                end
            end
            dfd_pkg::FSM_MOVE:
            begin
                // One byte per ack, never two in a row, so the occupancy
                // has a cycle to follow the byte before the next decision.
                if (byte_req_i && !st_r.ack && (st_r.count != dfd_pkg::CNT_ZERO)
                    && (lvl_host != dfd_pkg::LVL_RST))
                begin
                    st_nxt.ack      = 1'b1;
                    st_nxt.count    = st_r.count - dfd_pkg::CNT_ONE; // RQ4
                    st_nxt.host_ptr = st_r.host_ptr + dfd_pkg::PTR_ONE; // RQ8
                    if (st_r.count == dfd_pkg::CNT_ONE)
                    begin
                        st_nxt.fsm = dfd_pkg::FSM_DONE; // RQ5
                    end
                end
            end
            dfd_pkg::FSM_DONE:
            begin
                // Signal completion for one cycle and return to idle.
                st_nxt.done = 1'b1;
                st_nxt.fsm  = dfd_pkg::FSM_IDLE;
            end
            default:
            begin
                st_nxt.fsm = dfd_pkg::FSM_IDLE;
            end
        endcase
        // Busy is registered from the next state so the port comes off a flop.
        st_nxt.busy = (st_nxt.fsm != dfd_pkg::FSM_IDLE);
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            st_r.fsm       <= dfd_pkg::FSM_IDLE;
            st_r.count     <= dfd_pkg::CNT_ZERO;
            st_r.dir       <= 1'b0;
            st_r.host_ptr  <= dfd_pkg::PTR_RST;
            st_r.start_ptr <= dfd_pkg::PTR_RST;
            st_r.gid_seen  <= dfd_pkg::GID_RST;
            st_r.host_lvl  <= dfd_pkg::LVL_RST;
            st_r.net_ptr   <= dfd_pkg::PTR_RST;
            st_r.net_lvl   <= dfd_pkg::LVL_RST;
            st_r.ack       <= 1'b0;
            st_r.done      <= 1'b0;
            st_r.busy      <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Pack the diagnostic words; bits not written here stay zero.
    always_comb
    begin
        diag0_w = dfd_pkg::WORD_ZERO; // RQ1
        diag0_w[dfd_pkg::D0_START_LSB +: dfd_pkg::PTR_W] = st_r.start_ptr;
        diag0_w[dfd_pkg::CNT_W-1:0] = st_r.count;
        diag1_w = dfd_pkg::WORD_ZERO; // RQ1
        diag1_w[dfd_pkg::D1_STATE_LSB +: 4] = st_r.fsm; // RQ6
        diag1_w[dfd_pkg::D1_DIR_BIT] = st_r.dir; // RQ7
        diag1_w[dfd_pkg::D1_PTR_LSB +: dfd_pkg::PTR_W] = st_r.host_ptr;
        diag1_w[dfd_pkg::LVL_W-1:0] = st_r.host_lvl;
        diag2_w = dfd_pkg::WORD_ZERO; // RQ1
        diag2_w[dfd_pkg::D2_PTR_LSB +: dfd_pkg::PTR_W] = st_r.net_ptr;
        diag2_w[dfd_pkg::LVL_W-1:0] = st_r.net_lvl;
    end

    // Register bus slave; write data is not used by any register.
    dfd_apb u_apb (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .paddr_i    (paddr_i),
        .diag0_i    (diag0_w),
        .diag1_i    (diag1_w),
        .diag2_i    (diag2_w),
        .prdata_o   (prdata_o),
        .pready_o   (pready_o),
        .pslverr_o  (pslverr_o)
    );

    // Outputs straight from the state register.
    assign xfer_busy_o                = st_r.busy;
    assign xfer_done_o                = st_r.done;
    assign byte_ack_o                 = st_r.ack;
    assign host_side_buffer_pointer_o = st_r.host_ptr;
    assign host_side_buffer_level_o   = st_r.host_lvl;
    assign net_side_buffer_level_o    = st_r.net_lvl;

    // Reserved bits of any answered read are zero.
    AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ1
        pready_o && !pwrite_i |-> (prdata_o & (paddr_i == dfd_pkg::ADDR_DIAG0 ? dfd_pkg::D0_RSVD
            : paddr_i == dfd_pkg::ADDR_DIAG1 ? dfd_pkg::D1_RSVD : dfd_pkg::D2_RSVD)) == 0)
        else $error("Reserved diagnostic bit read as one.");

    // The start pointer only moves when the grant changed the cycle before.
    AST_START_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ2
        $changed(st_r.start_ptr) |-> $past(grant_sync[dfd_pkg::PTR_W +: dfd_pkg::GID_W])
            != $past(st_r.gid_seen))
        else $error("Start pointer changed without a new grant.");

    // Each moved byte lowers the countdown by exactly one.
    AST_COUNT_STEP: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ4
        st_r.ack |-> st_r.count == $past(st_r.count) - dfd_pkg::CNT_ONE)
        else $error("Countdown did not step by one on a byte.");

    // With the countdown at zero, in any state, no byte is acknowledged next.
    AST_STOP_AT_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ5
        st_r.count == dfd_pkg::CNT_ZERO |=> !st_r.ack)
        else $error("Byte moved with countdown at zero.");

    // The state field of a read shows the state machine at the access.
    AST_STATE_FIELD: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ6
        pready_o && !pwrite_i && paddr_i == dfd_pkg::ADDR_DIAG1
        |-> prdata_o[dfd_pkg::D1_STATE_LSB +: 4] == $past(st_r.fsm))
        else $error("State field does not match the state machine.");

    // The direction bit follows the direction taken at transfer start.
    AST_DIR_FIELD: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ7
        st_r.fsm == dfd_pkg::FSM_IDLE && xfer_start_i
        |=> st_r.dir == $past(memory_to_buffer_dir_i)
            ##1 st_r.dir == $past(memory_to_buffer_dir_i, 2))
        else $error("Direction not held after transfer start.");

    // The buffer pointer advances by one with each moved byte.
    AST_PTR_STEP: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ8
        st_r.ack |-> st_r.host_ptr == $past(st_r.host_ptr) + dfd_pkg::PTR_ONE)
        else $error("Buffer pointer did not advance with a byte.");

    // Both levels of a running transfer mirror each other around the size.
    AST_LEVEL_MIRROR: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ12
        st_r.fsm == dfd_pkg::FSM_MOVE ##1 st_r.fsm == dfd_pkg::FSM_MOVE
        |-> st_r.host_lvl + st_r.net_lvl == BUF_BYTES)
        else $error("Host and requester levels do not mirror.");

    // The requester pointer field follows its synchroniser by one cycle.
    AST_NET_PTR: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ11
        $past(reset_i) == 1'b0 |-> st_r.net_ptr == $past(nptr_sync))
        else $error("Requester pointer does not follow its synchroniser.");

    // A write to the first diagnostic address never turns into an error.
    AST_WRITE_QUIET: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ13
        pready_o && pwrite_i && paddr_i == dfd_pkg::ADDR_DIAG0 |-> !pslverr_o)
        else $error("Write to a diagnostic register flagged an error.");

    // Main scenarios.
    COV_FULL_XFER: cover property (@(posedge core_clk_i) st_r.ack ##[1:20] st_r.done);
    COV_READ_D1:   cover property (@(posedge core_clk_i)
        pready_o && !pwrite_i && paddr_i == dfd_pkg::ADDR_DIAG1);
    COV_WRITE:     cover property (@(posedge core_clk_i) pready_o && pwrite_i);
    COV_UNMAPPED:  cover property (@(posedge core_clk_i) pslverr_o);

endmodule // dfd_diag
`default_nettype wire

//--- dfd_host_model.sv
// Host bus master model that asks for bytes and tracks the buffer fill.
`timescale 1ns/10ps
`default_nettype none
module dfd_host_model (
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Bench control and byte handshake.
    input  wire logic        en_i,
    input  wire logic        dir_i,
    input  wire logic        byte_ack_i,
    output logic             byte_req_o,
    output logic      [12:0] buffer_used_o
);
    // The request is a plain level while the bench enables it.
    assign byte_req_o = en_i;

    // Each acked byte fills the buffer inbound or drains it outbound.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            buffer_used_o <= 13'h0020;
        end
        else if (byte_ack_i)
        begin
            buffer_used_o <= dir_i ? buffer_used_o + 13'h0001 : buffer_used_o - 13'h0001;
        end
    end
endmodule // dfd_host_model
`default_nettype wire

//--- dfd_pkg.sv
// Constants and types shared by the DMA transfer diagnostics block.
// Summary of operation
// [RQ1] Reserved diagnostic register bits always read zero.
// [RQ2] Start pointer held until another requester granted.
// [RQ3] Start pointer synchronised before it is observed.
// [RQ4] Byte countdown decrements once per moved byte.
// [RQ5] No byte moves once countdown is zero.
// [RQ6] Second register shows host side state machine.
// [RQ7] Direction reads one for memory to buffer.
// [RQ8] Host side pointer addresses current buffer byte.
// [RQ9] Host level: stored bytes out, empty in.
// [RQ10] Third register fields sampled by synchronised logic.
// [RQ11] Net side pointer follows active requester pointer.
// [RQ12] Net level: stored bytes in, empty out.
// [RQ13] Writes to diagnostic registers are ignored.
package dfd_pkg;

    // Register bus geometry and register byte addresses.
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] ADDR_DIAG0 = 12'h110;
    localparam logic [11:0] ADDR_DIAG1 = 12'h114;
    localparam logic [11:0] ADDR_DIAG2 = 12'h118;

    // Field widths.
    localparam int PTR_W = 13;
    localparam int CNT_W = 12;
    localparam int LVL_W = 13;
    localparam int GID_W = 3;

    // Field positions inside the diagnostic words.
    localparam int D0_START_LSB = 16;
    localparam int D1_STATE_LSB = 28;
    localparam int D1_DIR_BIT   = 26;
    localparam int D1_PTR_LSB   = 13;
    localparam int D2_PTR_LSB   = 16;

    // Masks of the reserved bits of each diagnostic word.
    localparam logic [31:0] D0_RSVD = 32'hE000F000;
    localparam logic [31:0] D1_RSVD = 32'h08000000;
    localparam logic [31:0] D2_RSVD = 32'hE000E000;

    // Reset values and step constants.
    localparam logic [12:0] BUF_BYTES_DEF = 13'h1000;
    localparam logic [12:0] PTR_RST       = 13'h0000;
    localparam logic [12:0] PTR_ONE       = 13'h0001;
    localparam logic [12:0] LVL_RST       = 13'h0000;
    localparam logic [11:0] CNT_ZERO      = 12'h000;
    localparam logic [11:0] CNT_ONE       = 12'h001;
    localparam logic [2:0]  GID_RST       = 3'h0;
    localparam logic [31:0] WORD_ZERO     = 32'h00000000;

    // States of the host side transfer state machine.
    typedef enum logic [3:0] {FSM_IDLE, FSM_LOAD, FSM_MOVE, FSM_DONE} dfd_fsm_t;

endpackage

//--- dfd_sync.sv
// Three stage synchroniser bank that accepts a value once two stages agree.
`timescale 1ns/10ps
`default_nettype none
module dfd_sync #(
    parameter int W = 16
) (
    // Clock and reset.
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // Asynchronous value in, settled value out.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    // All synchroniser state.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dfd_sync_st_t;

    dfd_sync_st_t st_r;   // Registered state.
    dfd_sync_st_t st_nxt; // Next state.

    // The first stage feeds only the second; the output takes a new value
    // only when stages two and three agree, so a skewed word is never seen.
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.q = st_r.s3; // RQ3
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.q;

    // The output only moves to a value that two stages held in agreement.
    AST_SYNC_AGREE: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ3
        $changed(st_r.q) |-> $past(st_r.s2 == st_r.s3) && (st_r.q == $past(st_r.s3)))
        else $error("Synchroniser output moved without agreement.");

endmodule // dfd_sync
`default_nettype wire

//--- tb.sv
// Self-checking bench for the DMA transfer diagnostics block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    // Bench signals.
    logic        clk, rst, psel, pen, pwr, start, dir, en, pready, pslverr;
    logic        busy, done, req, ack, err;
    logic [11:0] paddr, cnt;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] hptr, hlvl, used, sptr, nptr, nlvl;
    logic [2:0]  gid;
    int          miscompares, n_checks, acks;

    // Design with a small buffer so the levels stay readable.
    dfd_diag #(.BUF_BYTES(13'h0040)) dfd_diag_i (.core_clk_i(clk), .reset_i(rst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .xfer_start_i(start), .xfer_count_i(cnt), .memory_to_buffer_dir_i(dir),
        .xfer_busy_o(busy), .xfer_done_o(done), .byte_req_i(req), .byte_ack_o(ack),
        .host_side_buffer_pointer_o(hptr), .host_side_buffer_level_o(hlvl),
        .buffer_used_i(used), .grant_id_i(gid), .transfer_start_pointer_i(sptr),
        .net_side_buffer_pointer_i(nptr), .net_side_buffer_level_o(nlvl));

    // Host master partner.
    dfd_host_model dfd_host_model_i (.core_clk_i(clk), .reset_i(rst), .en_i(en),
        .dir_i(dir), .byte_ack_i(ack), .byte_req_o(req), .buffer_used_o(used));

    // Clock at 20 MHz.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Counts moved bytes.
    always @(posedge clk)
    begin
        if (ack === 1'b1)
            acks <= acks + 1;
    end

    // Compares one value and reports a mismatch.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // One APB transfer held until pready is seen high.
    task apb(input logic w, input logic [11:0] a);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= 32'hFFFFFFFF;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask

    // Reads a register and compares its masked word.
    task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask

    // Starts a transfer and lets it reach the move state, or the done state for a zero count.
    task go(input logic d, input logic [11:0] c);
        repeat (2) @(posedge clk);
        dir <= d; cnt <= c; start <= 1'b1; acks <= 0;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        chk("busy", 1, busy);
    endtask

    // Waits for the end of the transfer and checks the bytes moved.
    task fin(input int n_exp);
        int n;
        en <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk("done", 1, done === 1'b1);
        chk("idle", 0, busy);
        @(posedge clk);
        en <= 1'b0;
        chk("bytes", n_exp, acks);
    endtask

    // Reserved bits and idle state after reset.
    task t_reset;
        rchk(12'h110, dfd_pkg::D0_RSVD, 0);
        rchk(12'h114, 32'hFFFFE000, 0);
        rchk(12'h118, dfd_pkg::D2_RSVD, 0);
    endtask

    // Start pointer captured on a grant change and then held.
    task t_grant;
        sptr <= 13'h0ABC;
        repeat (10) @(posedge clk);
        gid <= 3'h1;
        repeat (10) @(posedge clk);
        sptr <= 13'h0123;
        repeat (10) @(posedge clk);
        rchk(12'h110, 32'hFFFF0000, 32'h0ABC0000);
    endtask

    // Inbound transfer of three bytes, with an ignored write on the way.
    task t_inbound;
        go(1'b1, 12'h003);
        rchk(12'h114, 32'hFFFFFFFF, {dfd_pkg::FSM_MOVE, 2'b01, 13'h0ABC, 13'h0020});
        rchk(12'h118, 32'hFFFFFFFF, {3'h0, 13'h0155, 3'h0, 13'h0020});
        apb(1'b1, 12'h110);
        rchk(12'h110, 32'hFFFFFFFF, 32'h0ABC0003);
        fin(3);
        rchk(12'h110, 32'h00000FFF, 0);
    endtask

    // Outbound transfer of two bytes and a transfer of zero bytes.
    task t_outbound;
        go(1'b0, 12'h002);
        chk("hptr", 13'h0ABC, hptr);
        chk("hlvl", 13'h0023, hlvl);
        chk("nlvl", 13'h001D, nlvl);
        rchk(12'h114, 32'hFFFFFFFF, {dfd_pkg::FSM_MOVE, 2'b00, 13'h0ABC, 13'h0023});
        rchk(12'h118, 32'h00001FFF, 32'h0000001D);
        fin(2);
        rchk(12'h114, 32'h07FFE000, {6'h00, 13'h0ABE, 13'h0000});
        go(1'b1, 12'h000);
        fin(0);
    endtask

    // Unmapped address answers with an error and zero data.
    task t_unmapped;
        apb(1'b0, 12'h11C);
        chk("slverr", 1, err);
        chk("unmapped data", 0, rd);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000;
        pwdata = 32'h00000000; start = 1'b0; cnt = 12'h000; dir = 1'b0; en = 1'b0;
        gid = 3'h0; sptr = 13'h0000; nptr = 13'h0155; acks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_grant;
        t_inbound;
        t_outbound;
        t_unmapped;
        results;
    end

    // Cuts a hang short.
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results;
    end
endmodule // tb
`default_nettype wire
